// ### core/drfs_pkg.sv
// Package of constants and types for the DDR rail fault sequencer
package drfs_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned SS_CYCLES      = 128;
    localparam int unsigned SS_TIME_US     = 320;
    localparam int unsigned SS_CNT_W       = 8;
    localparam int unsigned FAULT_QUAL     = 4;
    localparam int unsigned QUAL_W         = 3;
    localparam logic        ILIM_LOW       = 1'b0;
    localparam logic        ILIM_HIGH      = 1'b1;
    localparam logic [SS_CNT_W-1:0] SS_RESET = 8'h00;
    localparam logic [QUAL_W-1:0]   QUAL_RESET = 3'h0;

    typedef enum logic [1:0] {
        DRFS_S5,
        DRFS_S3,
        DRFS_S0
    } drfs_state_t;
endpackage

// ### core/drfs_qual_if.sv
// Interface carrying fault comparator level and qualified result
`timescale 1ns/1ps
interface drfs_qual_if;
    logic cond;
    logic clear;
    logic hit;
    modport src (output cond, output clear, input hit);
    modport qual (input cond, input clear, output hit);
endinterface

// ### core/drfs_qual.sv
// Four-cycle fault qualifier with sticky latch
`timescale 1ns/1ps
module drfs_qual (
    input  wire logic   mclk,
    input  wire logic   rst,
    drfs_qual_if.qual   q
);
    logic [drfs_pkg::QUAL_W-1:0] cnt;
    logic [drfs_pkg::QUAL_W-1:0] next_cnt;
    logic                        latched;
    logic                        next_latched;

    always_comb begin
        next_cnt     = cnt;
        next_latched = latched;
        if (!q.cond) begin
            next_cnt = drfs_pkg::QUAL_RESET;
        end else if (cnt < drfs_pkg::QUAL_W'(drfs_pkg::FAULT_QUAL)) begin
            next_cnt = cnt + 3'h1;
        end
        if (next_cnt == drfs_pkg::QUAL_W'(drfs_pkg::FAULT_QUAL)) begin
            next_latched = 1'b1;
        end else if (q.clear) begin
            // A fault arriving with the clear still wins
            next_latched = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt     <= drfs_pkg::QUAL_RESET;
            latched <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            latched <= next_latched;
        end
    end

    assign q.hit = latched;
endmodule

// ### core/drfs_softstart.sv
// Termination soft-start current limit sequencer
`timescale 1ns/1ps
module drfs_softstart (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic enable,
    output logic      ilim_high
);
    logic [drfs_pkg::SS_CNT_W:0] cnt;
    logic [drfs_pkg::SS_CNT_W:0] next_cnt;
    logic                        next_ilim;

    always_comb begin
        next_cnt  = cnt;
        next_ilim = drfs_pkg::ILIM_LOW;
        if (!enable) begin
            next_cnt = '0;
        end else if (cnt < 9'(drfs_pkg::SS_CYCLES)) begin
            next_cnt = cnt + 9'h001;
        end
        if (enable && next_cnt >= 9'(drfs_pkg::SS_CYCLES)) begin
            next_ilim = drfs_pkg::ILIM_HIGH;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt       <= '0;
            ilim_high <= drfs_pkg::ILIM_LOW;
        end else begin
            cnt       <= next_cnt;
            ilim_high <= next_ilim;
        end
    end
endmodule

// ### core/drfs_top.sv
// Control and fault logic of the DDR rail power sequencer
`timescale 1ns/1ps
module drfs_top (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic main_enable,
    input  wire logic termination_enable,
    input  wire logic force_pwm,
    input  wire logic supply_ok_cmp,
    input  wire logic input_rail_ok,
    input  wire logic temp_over_hi,
    input  wire logic temp_under_lo,
    input  wire logic rail_regulated_cmp,
    input  wire logic rail_above_window,
    input  wire logic rail_below_window,
    input  wire logic rail_above_106,
    input  wire logic rail_above_130,
    input  wire logic rail_below_94,
    input  wire logic rail_below_65,
    input  wire logic rail_at_nominal,
    input  wire logic high_side_overcurrent,
    output logic      supply_good,
    output logic      rail_in_regulation,
    output logic      memory_rail_enable,
    output logic      memory_rail_softstart,
    output logic      buffered_reference_enable,
    output logic      termination_regulator_enable,
    output logic      termination_rail_hiz,
    output logic      termination_ilim_high,
    output logic      high_side_enable,
    output logic      high_side_force_off,
    output logic      low_side_force_on,
    output logic      power_saving,
    output logic      output_window_ok_out,
    output logic      output_window_ok_oe,
    output logic      ov_fault,
    output logic      uv_fault,
    output logic      oc_fault,
    output logic      thermal_shutdown,
    output logic [1:0] sleep_state
);
    // Two-flop synchronisers for every pin and comparator level
    localparam int unsigned NSYNC = 16;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;

    assign raw = {main_enable, termination_enable, force_pwm, supply_ok_cmp, input_rail_ok,
                  temp_over_hi, temp_under_lo, rail_regulated_cmp, rail_above_window,
                  rail_below_window, rail_above_106, rail_above_130, rail_below_94,
                  rail_below_65, rail_at_nominal, high_side_overcurrent};

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    logic en_s;
    logic tten_s;
    logic fpwm_s;
    logic vcc_s;
    logic vin_s;
    logic tover_s;
    logic tunder_s;
    logic reg_s;
    logic win_hi_s;
    logic win_lo_s;
    logic a106_s;
    logic a130_s;
    logic b94_s;
    logic b65_s;
    logic nom_s;
    logic oc_s;
    assign {en_s, tten_s, fpwm_s, vcc_s, vin_s, tover_s, tunder_s, reg_s,
            win_hi_s, win_lo_s, a106_s, a130_s, b94_s, b65_s, nom_s, oc_s} = sync2;

    // Delayed copies of the clearing sources, for edge detection
    logic en_d;
    logic vcc_d;
    logic vin_d;
    logic next_en_d;
    logic next_vcc_d;
    logic next_vin_d;
    logic cycle_evt;
    assign next_en_d  = en_s;
    assign next_vcc_d = vcc_s;
    assign next_vin_d = vin_s;
    // Any edge on these sources counts as a cycle of that supply
    assign cycle_evt  = (en_s ^ en_d) | (vcc_s ^ vcc_d) | (vin_s ^ vin_d);

    // State and latched flags
    drfs_pkg::drfs_state_t state;
    drfs_pkg::drfs_state_t next_state;
    logic                  hot;
    logic                  next_hot;
    logic                  rail_reg;
    logic                  next_rail_reg;
    logic                  fpwm_boost;
    logic                  next_fpwm_boost;
    logic                  ov_clamp;
    logic                  next_ov_clamp;
    logic                  any_fault;

    drfs_qual_if ov_q ();
    drfs_qual_if uv_q ();
    drfs_qual_if oc_q ();

    assign ov_q.cond  = a130_s;
    assign ov_q.clear = cycle_evt;
    assign uv_q.cond  = b65_s && (state != drfs_pkg::DRFS_S5);
    assign uv_q.clear = cycle_evt;
    // Overcurrent clears only on enable or control supply, not input rail
    assign oc_q.cond  = oc_s && (state != drfs_pkg::DRFS_S5);
    assign oc_q.clear = (en_s ^ en_d) | (vcc_s ^ vcc_d);

    drfs_qual u_ov_qual (
        .mclk (mclk),
        .rst  (rst),
        .q    (ov_q)
    );

    drfs_qual u_uv_qual (
        .mclk (mclk),
        .rst  (rst),
        .q    (uv_q)
    );

    drfs_qual u_oc_qual (
        .mclk (mclk),
        .rst  (rst),
        .q    (oc_q)
    );

    assign any_fault = ov_q.hit | uv_q.hit | oc_q.hit | hot;

    always_comb begin
        next_hot = hot;
        if (tover_s) begin
            next_hot = 1'b1;
        end else if (tunder_s) begin
            next_hot = 1'b0;
        end
    end

    always_comb begin
        next_state = drfs_pkg::DRFS_S5;
        // Low main_enable or a missing supply always lands in S5
        if (en_s && vcc_s && vin_s && !any_fault) begin
            next_state = tten_s ? drfs_pkg::DRFS_S0 : drfs_pkg::DRFS_S3;
        end
    end

    always_comb begin
        next_rail_reg = 1'b0;
        if (state != drfs_pkg::DRFS_S5 && !ov_clamp) begin
            next_rail_reg = reg_s;
        end
    end

    always_comb begin
        next_ov_clamp = ov_clamp;
        if (a106_s && !a130_s) begin
            next_ov_clamp = 1'b1;
        end else if (nom_s || !a106_s) begin
            next_ov_clamp = 1'b0;
        end
        if (state == drfs_pkg::DRFS_S5) begin
            next_ov_clamp = 1'b0;
        end
    end

    always_comb begin
        next_fpwm_boost = fpwm_boost;
        if (b94_s) begin
            next_fpwm_boost = 1'b1;
        end else if (nom_s) begin
            next_fpwm_boost = 1'b0;
        end
        if (state != drfs_pkg::DRFS_S3) begin
            next_fpwm_boost = 1'b0;
        end
    end

    // Reset low like the sync flops, so no false edge follows reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            en_d  <= 1'b0;
            vcc_d <= 1'b0;
            vin_d <= 1'b0;
        end else begin
            en_d  <= next_en_d;
            vcc_d <= next_vcc_d;
            vin_d <= next_vin_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= drfs_pkg::DRFS_S5;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hot <= 1'b0;
        end else begin
            hot <= next_hot;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rail_reg <= 1'b0;
        end else begin
            rail_reg <= next_rail_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ov_clamp <= 1'b0;
        end else begin
            ov_clamp <= next_ov_clamp;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fpwm_boost <= 1'b0;
        end else begin
            fpwm_boost <= next_fpwm_boost;
        end
    end

    // Termination regulator enable and its soft-start
    logic tt_on;
    assign tt_on = (state == drfs_pkg::DRFS_S0) && tten_s && rail_reg;

    drfs_softstart u_ss (
        .mclk      (mclk),
        .rst       (rst),
        .enable    (tt_on),
        .ilim_high (termination_ilim_high)
    );

    // Registered outputs
    logic next_ww_low;
    logic on_state;
    assign on_state    = (state != drfs_pkg::DRFS_S5);
    // Window comparator is ignored in S5 where the pin is held low anyway
    assign next_ww_low = !on_state || win_hi_s || win_lo_s;

    logic       next_supply_good;
    logic       next_rail_in_regulation;
    logic       next_memory_rail_enable;
    logic       next_memory_rail_softstart;
    logic       next_buffered_reference_enable;
    logic       next_termination_regulator_enable;
    logic       next_termination_rail_hiz;
    logic       next_high_side_enable;
    logic       next_high_side_force_off;
    logic       next_low_side_force_on;
    logic       next_power_saving;
    logic [1:0] next_sleep_state;

    always_comb begin
        next_supply_good                  = vcc_s;
        next_rail_in_regulation           = rail_reg;
        next_memory_rail_enable           = on_state;
        next_memory_rail_softstart        = on_state && !rail_reg;
        next_buffered_reference_enable    = on_state && en_s;
        next_termination_regulator_enable = tt_on;
        next_termination_rail_hiz         = !tt_on;
        next_high_side_enable             = on_state && !ov_clamp;
        next_high_side_force_off          = !on_state || ov_clamp;
        next_low_side_force_on            = on_state && ov_clamp;
        next_power_saving                 = (state == drfs_pkg::DRFS_S3) && fpwm_s && !fpwm_boost;
        next_sleep_state                  = 2'(state);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            supply_good                  <= 1'b0;
            rail_in_regulation           <= 1'b0;
            memory_rail_enable           <= 1'b0;
            memory_rail_softstart        <= 1'b0;
            buffered_reference_enable    <= 1'b0;
            termination_regulator_enable <= 1'b0;
            termination_rail_hiz         <= 1'b1;
            high_side_enable             <= 1'b0;
            high_side_force_off          <= 1'b1;
            low_side_force_on            <= 1'b0;
            power_saving                 <= 1'b0;
            output_window_ok_oe          <= 1'b1;
            sleep_state                  <= 2'h0;
        end else begin
            supply_good                  <= next_supply_good;
            rail_in_regulation           <= next_rail_in_regulation;
            memory_rail_enable           <= next_memory_rail_enable;
            memory_rail_softstart        <= next_memory_rail_softstart;
            buffered_reference_enable    <= next_buffered_reference_enable;
            termination_regulator_enable <= next_termination_regulator_enable;
            termination_rail_hiz         <= next_termination_rail_hiz;
            high_side_enable             <= next_high_side_enable;
            high_side_force_off          <= next_high_side_force_off;
            low_side_force_on            <= next_low_side_force_on;
            power_saving                 <= next_power_saving;
            output_window_ok_oe          <= next_ww_low;
            sleep_state                  <= next_sleep_state;
        end
    end

    assign output_window_ok_out = 1'b0;
    assign ov_fault             = ov_q.hit;
    assign uv_fault             = uv_q.hit;
    assign oc_fault             = oc_q.hit;
    assign thermal_shutdown     = hot;
endmodule

// ### dv/drfs_rail_cmp.sv
// Comparator model that turns the memory rail level into threshold flags
`timescale 1ns/1ps
module drfs_rail_cmp (
    input  wire logic [7:0] rail_pct,
    output logic            rail_regulated_cmp,
    output logic            rail_above_window,
    output logic            rail_below_window,
    output logic            rail_above_106,
    output logic            rail_above_130,
    output logic            rail_below_94,
    output logic            rail_below_65,
    output logic            rail_at_nominal
);
    // Level is in percent of nominal; a level exactly on a threshold reads as inside
    always_comb begin
        rail_above_window  = rail_pct > 8'h70;
        rail_below_window  = rail_pct < 8'h58;
        rail_regulated_cmp = !rail_above_window && !rail_below_window;
        rail_above_106     = rail_pct > 8'h6A;
        rail_above_130     = rail_pct > 8'h82;
        rail_below_94      = rail_pct < 8'h5E;
        rail_below_65      = rail_pct < 8'h41;
        rail_at_nominal    = rail_pct == 8'h64;
    end
endmodule

// ### dv/drfs_top_checker.sv
// Assertion checker on the ports of the DDR rail fault sequencer
`timescale 1ns/1ps
module drfs_top_checker (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       supply_ok_cmp,
    input wire logic       rail_above_130,
    input wire logic       rail_above_window,
    input wire logic       rail_below_window,
    input wire logic       temp_over_hi,
    input wire logic       supply_good,
    input wire logic       termination_regulator_enable,
    input wire logic       termination_rail_hiz,
    input wire logic       termination_ilim_high,
    input wire logic       high_side_enable,
    input wire logic       output_window_ok_oe,
    input wire logic       ov_fault,
    input wire logic       uv_fault,
    input wire logic       oc_fault,
    input wire logic       thermal_shutdown,
    input wire logic       memory_rail_enable,
    input wire logic [1:0] sleep_state
);
    logic [7:0] ss_cnt;
    logic [7:0] next_ss_cnt;

    // Saturates so a long enable never wraps back into the low limit window
    always_comb begin
        next_ss_cnt = ss_cnt;
        if (rst || !termination_regulator_enable) begin
            next_ss_cnt = 8'h00;
        end else if (ss_cnt != 8'hFF) begin
            next_ss_cnt = ss_cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        ss_cnt <= next_ss_cnt;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_supply_follow: assert property (supply_ok_cmp [*7] |-> supply_good)
        else $error("supply_good low with supply present");
    a_supply_fail: assert property (!supply_ok_cmp [*7] |-> sleep_state == 2'h0)
        else $error("not in S5 after supply loss");
    a_hiz_in_s3: assert property ((sleep_state == 2'h1) [*3] |->
        termination_rail_hiz && !termination_regulator_enable)
        else $error("termination driven in S3");
    a_ilim_early: assert property (termination_ilim_high && termination_regulator_enable |->
        ss_cnt > 8'h7D)
        else $error("current limit raised too early");
    a_ilim_late: assert property (ss_cnt == 8'h84 |-> termination_ilim_high)
        else $error("current limit not raised");
    a_ilim_cleared: assert property (!termination_regulator_enable [*2] |-> !termination_ilim_high)
        else $error("current limit high while regulator off");
    a_ov_latch: assert property (rail_above_130 [*8] |-> ##[0:3] ov_fault)
        else $error("overvoltage not latched");
    a_ov_filter: assert property ((!rail_above_130 && !ov_fault) [*4] ##1 rail_above_130 [*3]
        ##1 !rail_above_130 [*6] |-> !ov_fault)
        else $error("overvoltage latched on a short excursion");
    // Latch, then state, then switch flop: the switch drops two edges after the fault
    a_fault_off: assert property ((ov_fault || uv_fault || oc_fault) [*3] |-> !high_side_enable)
        else $error("high side switching during a fault");
    a_window_pull: assert property ((rail_above_window || rail_below_window) [*7] |->
        output_window_ok_oe)
        else $error("window output released outside window");
    a_thermal_off: assert property (temp_over_hi [*7] |-> thermal_shutdown && !memory_rail_enable)
        else $error("no shutdown when hot");
endmodule

bind drfs_top drfs_top_checker chk_u (.*);

// ### dv/test_drfs_top.sv
// Self-checking testbench of the DDR rail fault sequencer
`timescale 1ns/1ps
module test_drfs_top;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       main_enable, termination_enable, force_pwm, supply_ok_cmp, input_rail_ok;
    logic       temp_over_hi, temp_under_lo, high_side_overcurrent, rail_regulated_cmp;
    logic       rail_above_window, rail_below_window, rail_above_106, rail_above_130;
    logic       rail_below_94, rail_below_65, rail_at_nominal, supply_good, rail_in_regulation;
    logic       memory_rail_enable, memory_rail_softstart, buffered_reference_enable;
    logic       termination_regulator_enable, termination_rail_hiz, termination_ilim_high;
    logic       high_side_enable, high_side_force_off, low_side_force_on, power_saving;
    logic       output_window_ok_out, output_window_ok_oe, ov_fault, uv_fault, oc_fault;
    logic       thermal_shutdown;
    logic [1:0] sleep_state;
    logic [7:0] rail_pct;
    int         n_fail = 0;
    int         compares = 0;

    drfs_rail_cmp model (.*);
    drfs_top dut (.*);

    always #5 mclk = ~mclk;

    // Ends 2 ns past the edge so registered outputs have settled
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic rail(input logic [7:0] v, input int n);
        @(posedge mclk);
        rail_pct <= v;
        step(n);
    endtask

    task automatic chk(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            $display("unexpected %s expected %b seen %b", name, exp, got);
            n_fail++;
        end
    endtask

    task automatic chk_state(input string name, input logic [1:0] exp);
        compares++;
        if (sleep_state !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, sleep_state);
            n_fail++;
        end
    endtask

    task automatic t_reset();
        chk("od_level", 1'b0, output_window_ok_out);
        chk("hiz", 1'b1, termination_rail_hiz);
        chk("pull_low", 1'b1, output_window_ok_oe);
    endtask

    task automatic t_power_up();
        @(posedge mclk);
        {main_enable, supply_ok_cmp, input_rail_ok, termination_enable} <= 4'hF;
        step(10);
        chk("supply_good", 1'b1, supply_good);
        chk("reference", 1'b1, buffered_reference_enable);
        chk("in_reg", 1'b1, rail_in_regulation);
        chk("term_on", 1'b1, termination_regulator_enable);
        chk("ilim_low", 1'b0, termination_ilim_high);
        chk("window_ok", 1'b0, output_window_ok_oe);
        chk("ss_done", 1'b0, memory_rail_softstart);
        chk("hs_on", 1'b1, high_side_enable);
        step(130);
        chk("ilim_high", 1'b1, termination_ilim_high);
    endtask

    task automatic t_s3();
        @(posedge mclk);
        {termination_enable, force_pwm} <= 2'h1;
        step(8);
        chk_state("s3", 2'h1);
        chk("hiz_s3", 1'b1, termination_rail_hiz);
        chk("term_off", 1'b0, termination_regulator_enable);
        chk("ref_s3", 1'b1, buffered_reference_enable);
        chk("saving", 1'b1, power_saving);
        rail(8'h5A, 8);
        chk("boost", 1'b0, power_saving);
        rail(8'h64, 8);
        chk("resume", 1'b1, power_saving);
        @(posedge mclk);
        termination_enable <= 1'b1;
        step(12);
        chk("restart_on", 1'b1, termination_regulator_enable);
        chk("restart_low", 1'b0, termination_ilim_high);
        step(130);
        chk("restart_high", 1'b1, termination_ilim_high);
    endtask

    task automatic t_window();
        rail(8'h6E, 8);
        chk("inside", 1'b0, output_window_ok_oe);
        chk("clamp_hs", 1'b1, high_side_force_off);
        chk("clamp_ls", 1'b1, low_side_force_on);
        chk("hs_clamp", 1'b0, high_side_enable);
        chk("ss_clamp", 1'b1, memory_rail_softstart);
        rail(8'h73, 8);
        chk("above", 1'b1, output_window_ok_oe);
        rail(8'h55, 8);
        chk("below", 1'b1, output_window_ok_oe);
        rail(8'h64, 8);
        chk("release", 1'b0, high_side_force_off);
        chk("hs_release", 1'b1, high_side_enable);
        chk("ss_release", 1'b0, memory_rail_softstart);
    endtask

    task automatic t_ov();
        rail(8'h87, 2);
        rail(8'h64, 8);
        chk("short_ov", 1'b0, ov_fault);
        rail(8'h87, 10);
        chk("ov_set", 1'b1, ov_fault);
        chk("ov_ls", 1'b0, low_side_force_on);
        chk("ov_hs", 1'b0, high_side_enable);
        rail(8'h64, 8);
        chk("ov_held", 1'b1, ov_fault);
        @(posedge mclk);
        main_enable <= 1'b0;
        step(8);
        chk_state("off_s5", 2'h0);
        chk("ref_off", 1'b0, buffered_reference_enable);
        @(posedge mclk);
        main_enable <= 1'b1;
        step(12);
        chk("ov_clear", 1'b0, ov_fault);
        chk_state("ov_rerun", 2'h2);
    endtask

    task automatic t_uv();
        rail(8'h3C, 10);
        chk("uv_set", 1'b1, uv_fault);
        rail(8'h64, 8);
        chk("uv_held", 1'b1, uv_fault);
        @(posedge mclk);
        input_rail_ok <= 1'b0;
        step(8);
        @(posedge mclk);
        input_rail_ok <= 1'b1;
        step(12);
        chk("uv_clear", 1'b0, uv_fault);
        chk_state("uv_rerun", 2'h2);
    endtask

    task automatic t_supply_oc();
        @(posedge mclk);
        supply_ok_cmp <= 1'b0;
        step(8);
        chk("supply_low", 1'b0, supply_good);
        chk_state("supply_s5", 2'h0);
        @(posedge mclk);
        {supply_ok_cmp, high_side_overcurrent} <= 2'h3;
        step(14);
        chk("oc_set", 1'b1, oc_fault);
        chk("oc_rail", 1'b0, memory_rail_enable);
        @(posedge mclk);
        {supply_ok_cmp, high_side_overcurrent} <= 2'h0;
        step(8);
        @(posedge mclk);
        supply_ok_cmp <= 1'b1;
        step(12);
        chk("oc_clear", 1'b0, oc_fault);
    endtask

    task automatic t_thermal();
        @(posedge mclk);
        {temp_over_hi, temp_under_lo} <= 2'h2;
        step(8);
        chk("hot", 1'b1, thermal_shutdown);
        @(posedge mclk);
        temp_over_hi <= 1'b0;
        step(8);
        chk("cooling", 1'b1, thermal_shutdown);
        @(posedge mclk);
        temp_under_lo <= 1'b1;
        step(12);
        chk("cool", 1'b0, thermal_shutdown);
        chk_state("cool_s0", 2'h2);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        {main_enable, termination_enable, force_pwm, supply_ok_cmp} = 4'h0;
        {input_rail_ok, temp_over_hi, high_side_overcurrent} = 3'h0;
        temp_under_lo = 1'b1;
        rail_pct = 8'h64;
        step(20);
        t_reset();
        @(posedge mclk);
        rst <= 1'b0;
        t_power_up();
        t_s3();
        t_window();
        t_ov();
        t_uv();
        t_supply_oc();
        t_thermal();
        complete_run();
    end
endmodule
